//--- sim/prra_rate_adjust_tb.sv
/*
 * Self-checking bench for the clock rate-adjust block: an AHB-Lite master,
 * a tick driver and an integer model of live time compared at every result.
 * Assumes the slave answers with no wait states and hready is its own hreadyout.
 */
`timescale 1ns/1ps
`default_nettype none
module prra_rate_adjust_tb;

	// ***************************************************************
	// signals and model state
	// ***************************************************************
	localparam longint TWO32 = 64'h0000000100000000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic tick = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h00000000;
	wire logic hready;
	wire logic hresp;
	wire logic adj_active;
	wire logic [31:0] hrdata;
	wire logic [31:0] live_sec;
	wire logic [31:0] live_ns;
	int err_count = 0;
	int checks = 0;
	integer seed = 32'h687A077C;
	longint m_sec = 0;
	longint m_ns = 0;
	longint m_frac = 0;
	longint m_rate = 0;
	bit m_add = 1'b0;
	logic [31:0] rd;
	logic [31:0] wd;
	logic [15:0] regs [6];
	int dur;

	// 20 MHz reference clock
	always #25 clk = ~clk;

	prra_rate_adjust i_prra_rate_adjust (
		.i_ref_clk(clk),
		.i_rst(rst),
		.i_tick(tick),
		.i_hsel(hsel),
		.i_haddr(haddr),
		.i_htrans(htrans),
		.i_hwrite(hwrite),
		.i_hsize(hsize),
		.i_hwdata(hwdata),
		.i_hready(hready),
		.o_hrdata(hrdata),
		.o_hreadyout(hready),
		.o_hresp(hresp),
		.o_live_sec(live_sec),
		.o_live_ns(live_ns),
		.o_adj_active(adj_active)
	);

	// ***************************************************************
	// compare, bus and tick tasks
	// ***************************************************************
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// bounded wait; the master never assumes a latency
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1 && n < 64) begin
			@(posedge clk);
			n++;
		end
		if (n >= 64) begin
			err_count++;
			$display("Error hready expected 1 seen %b", hready);
			test_done();
		end
	endtask

	// one single word transfer; read data lands in rd
	task automatic ahb(input bit wr, input logic [15:0] idx, input logic [31:0] data);
		hsel <= 1'b1;
		haddr <= {14'h0000, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= prra_pkg::HSIZE_WORD;
		wait_ready();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= data;
		wait_ready();
		rd = hrdata;
	endtask

	// one timing step; carry or borrow moves ns by one, wrap at a second
	task automatic step(input bit adj);
		repeat ($unsigned($random(seed)) % 2) @(posedge clk);
		tick <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		if (adj) begin
			m_frac = m_add ? m_frac + m_rate : m_frac - m_rate;
			if (m_frac < 0) begin
				m_frac += TWO32;
				m_ns--;
			end else if (m_frac >= TWO32) begin
				m_frac -= TWO32;
				m_ns++;
			end
		end
		m_ns += prra_pkg::TICK_PERIOD_NS;
		if (m_ns >= prra_pkg::NS_PER_SEC) begin
			m_ns -= prra_pkg::NS_PER_SEC;
			m_sec++;
		end
		@(posedge clk);
		chk("live_ns", m_ns[31:0], live_ns);
		chk("live_sec", m_sec[31:0], live_sec);
	endtask

	task automatic test_done;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		regs = '{prra_pkg::IDX_SEC_HI, prra_pkg::IDX_SEC_LO, prra_pkg::IDX_RATE_HI,
			prra_pkg::IDX_RATE_LO, prra_pkg::IDX_DUR_HI, prra_pkg::IDX_DUR_LO};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("hresp", 32'h00000000, {31'h00000000, hresp});
		for (int i = 0; i < 6; i++) begin
			ahb(1'b0, regs[i], 32'h00000000);
			chk("reset_value", 32'h00000000, rd);
		end
		chk("adj_active", 32'h00000000, {31'h00000000, adj_active});
		$display("test reset done");
		// bit 14 kept clear so no temporary run starts here
		for (int i = 0; i < 6; i++) begin
			wd = $random(seed) & 32'hFFFFBFFF;
			ahb(1'b1, regs[i], wd);
			ahb(1'b0, regs[i], 32'h00000000);
			chk("readback", wd & 32'h0000FFFF, rd);
		end
		ahb(1'b1, 16'h0514, 32'h0000FFFF);
		ahb(1'b0, 16'h0514, 32'h00000000);
		chk("unmapped", 32'h00000000, rd);
		$display("test registers done");
		// load two steps short of a second, then let it wrap
		m_sec = $unsigned($random(seed));
		m_ns = prra_pkg::NS_PER_SEC - 80;
		m_frac = 0;
		ahb(1'b1, prra_pkg::IDX_SEC_HI, {16'h0000, m_sec[31:16]});
		ahb(1'b1, prra_pkg::IDX_SEC_LO, {16'h0000, m_sec[15:0]});
		ahb(1'b1, prra_pkg::IDX_NS_HI, {16'h0000, m_ns[31:16]});
		ahb(1'b1, prra_pkg::IDX_NS_LO, {16'h0000, m_ns[15:0]});
		ahb(1'b1, prra_pkg::IDX_CTRL, 32'h00000008);
		repeat (3) @(posedge clk);
		chk("live_sec", m_sec[31:0], live_sec);
		chk("live_ns", m_ns[31:0], live_ns);
		repeat (2) step(1'b0);
		$display("test load done");
		// large rates so carries and borrows come every few steps
		for (int d = 0; d < 2; d++) begin
			m_add = (d == 0);
			m_rate = 64'h20000000 | ($unsigned($random(seed)) & 32'h1FFFFFFF);
			ahb(1'b1, prra_pkg::IDX_RATE_LO, {16'h0000, m_rate[15:0]});
			ahb(1'b1, prra_pkg::IDX_RATE_HI, {16'h0000, m_add, 1'b0, m_rate[29:16]});
			ahb(1'b1, prra_pkg::IDX_CTRL, 32'h00000004);
			// enable lands at the edge that ends the data phase; look one edge later
			@(posedge clk);
			chk("adj_active", 32'h00000001, {31'h00000000, adj_active});
			repeat (12) step(1'b1);
			ahb(1'b1, prra_pkg::IDX_CTRL, 32'h00000000);
		end
		$display("test continuous done");
		// temporary run of a few steps, shared rate word
		dur = 3 + ($unsigned($random(seed)) % 4);
		m_add = $random(seed);
		ahb(1'b1, prra_pkg::IDX_DUR_HI, 32'h00000000);
		ahb(1'b1, prra_pkg::IDX_DUR_LO, dur);
		ahb(1'b1, prra_pkg::IDX_RATE_HI, {16'h0000, m_add, 1'b1, m_rate[29:16]});
		repeat (dur) step(1'b1);
		repeat (3) step(1'b0);
		ahb(1'b0, prra_pkg::IDX_RATE_HI, 32'h00000000);
		chk("rate_upper", {16'h0000, m_add, 1'b0, m_rate[29:16]}, rd);
		chk("adj_active", 32'h00000000, {31'h00000000, adj_active});
		// stop a long run part way through
		ahb(1'b1, prra_pkg::IDX_DUR_LO, 32'h00000014);
		ahb(1'b1, prra_pkg::IDX_RATE_HI, {16'h0000, m_add, 1'b1, m_rate[29:16]});
		repeat (3) step(1'b1);
		ahb(1'b1, prra_pkg::IDX_RATE_HI, {16'h0000, m_add, 1'b0, m_rate[29:16]});
		repeat (3) step(1'b0);
		chk("adj_active", 32'h00000000, {31'h00000000, adj_active});
		// a zero duration never starts a run
		ahb(1'b1, prra_pkg::IDX_DUR_LO, 32'h00000000);
		ahb(1'b1, prra_pkg::IDX_RATE_HI, {16'h0000, m_add, 1'b1, m_rate[29:16]});
		step(1'b0);
		chk("adj_active", 32'h00000000, {31'h00000000, adj_active});
		$display("test temporary done");
		// snapshot live time into the registers
		ahb(1'b1, prra_pkg::IDX_CTRL, 32'h00000010);
		repeat (3) @(posedge clk);
		ahb(1'b0, prra_pkg::IDX_SEC_HI, 32'h00000000);
		chk("sec_upper", {16'h0000, m_sec[31:16]}, rd);
		ahb(1'b0, prra_pkg::IDX_SEC_LO, 32'h00000000);
		chk("sec_lower", {16'h0000, m_sec[15:0]}, rd);
		ahb(1'b0, prra_pkg::IDX_NS_HI, 32'h00000000);
		chk("ns_upper", {16'h0000, m_ns[31:16]}, rd);
		ahb(1'b0, prra_pkg::IDX_NS_LO, 32'h00000000);
		chk("ns_lower", {16'h0000, m_ns[15:0]}, rd);
		$display("test snapshot done");
		test_done();
	end

	// watchdog well beyond the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		$display("Error watchdog expected finish seen timeout");
		test_done();
	end

endmodule
`default_nettype wire

//--- src/prra_pkg.sv
/*
 * Shared constants for the clock rate-adjust block: register indices,
 * field positions, reset values, temporary-adjust states and time counts.
 * Assumes nothing of its surroundings; every file names items as prra_pkg::name.
 */
package prra_pkg;

	// ***************************************************************
	// register indices (byte address is four times the index)
	// ***************************************************************
	localparam logic [15:0] IDX_CTRL = 16'h0500;
	localparam logic [15:0] IDX_PHASE = 16'h0502;
	localparam logic [15:0] IDX_NS_HI = 16'h0504;
	localparam logic [15:0] IDX_NS_LO = 16'h0506;
	localparam logic [15:0] IDX_SEC_HI = 16'h0508;
	localparam logic [15:0] IDX_SEC_LO = 16'h050A;
	localparam logic [15:0] IDX_RATE_HI = 16'h050C;
	localparam logic [15:0] IDX_RATE_LO = 16'h050E;
	localparam logic [15:0] IDX_DUR_HI = 16'h0510;
	localparam logic [15:0] IDX_DUR_LO = 16'h0512;

	// ***************************************************************
	// field positions and reset values
	// ***************************************************************
	localparam int CTRL_READ_BIT = 4;
	localparam int CTRL_LOAD_BIT = 3;
	localparam int CTRL_CONT_BIT = 2;
	localparam int RATE_SIGN_BIT = 15;
	localparam int RATE_TEMP_BIT = 14;
	localparam int RATE_HI_W = 14;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// ***************************************************************
	// time counts
	// ***************************************************************
	localparam logic [31:0] TICK_PERIOD_NS = 32'h00000028;
	localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00;

	// ***************************************************************
	// temporary-adjust states
	// ***************************************************************
	typedef enum logic [1:0] {
		TMP_IDLE = 2'h1,
		TMP_RUN = 2'h2
	} prra_tmp_state_t;

endpackage

//--- src/prra_rate_adjust.sv
/*
 * Clock rate-adjust block with AHB-Lite register slave, seconds registers,
 * shared rate word, temporary-adjust duration counter and read/load commands.
 * Assumes a single AHB-Lite master, word transfers, and a same-clock strobe
 * i_tick that marks each 40 ns timing period.
 *
// Overview of operation
// - The seconds count is 32 bits read/write, split over two 16-bit registers, reset zero.
// - The 30-bit rate sits as bits 29..16 in the upper register's low 14 bits and 15..0 below.
// - The sign bit set adds the rate each timing period, clear subtracts it.
// - One sign bit serves both temporary and continuous adjustment.
// - Setting the temporary bit applies the rate every period for the programmed duration.
// - Writing zero to the temporary bit stops a running temporary adjustment.
// - The duration is a 32-bit count of timing periods in two 16-bit registers.
// - Continuous and temporary adjustment share one stored rate value.
// - While continuous enable is set the rate applies every period without limit.
// - A read command copies the live clock into phase, nanosecond and seconds registers.
// - A load command sets the live clock from phase, nanosecond and seconds registers.
 */
`timescale 1ns/1ps
`default_nettype none
module prra_rate_adjust (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// timing strobe, one per 40 ns period
	input wire logic i_tick,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// live time and status
	output logic [31:0] o_live_sec,
	output logic [31:0] o_live_ns,
	output logic o_adj_active
);
	// ***************************************************************
	// address decode
	// ***************************************************************
	function automatic logic [15:0] f_index(input logic [31:0] addr);
		f_index = (addr[31:18] == 14'h0000 && addr[1:0] == 2'h0) ? addr[17:2] : 16'hFFFF;
	endfunction

	logic addr_ok, dwrite_q;
	logic [15:0] didx_q, rd_mux;
	logic [31:0] hrdata_q;
	logic wr_ctrl, wr_phase, wr_nshi, wr_nslo, wr_sechi, wr_seclo;
	logic wr_ratehi, wr_ratelo, wr_durhi, wr_durlo;

	// the slave never stalls, so hready from the one master is hreadyout
	assign addr_ok = i_hsel && i_hready && i_htrans[1] && (i_hsize == prra_pkg::HSIZE_WORD);

	// address phase captured; writes land at the end of the data phase
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			dwrite_q <= 1'b0;
			didx_q <= 16'h0000;
		end else begin
			dwrite_q <= addr_ok && i_hwrite;
			didx_q <= f_index(i_haddr);
		end
	end

	assign wr_ctrl = dwrite_q && didx_q == prra_pkg::IDX_CTRL;
	assign wr_phase = dwrite_q && didx_q == prra_pkg::IDX_PHASE;
	assign wr_nshi = dwrite_q && didx_q == prra_pkg::IDX_NS_HI;
	assign wr_nslo = dwrite_q && didx_q == prra_pkg::IDX_NS_LO;
	assign wr_sechi = dwrite_q && didx_q == prra_pkg::IDX_SEC_HI;
	assign wr_seclo = dwrite_q && didx_q == prra_pkg::IDX_SEC_LO;
	assign wr_ratehi = dwrite_q && didx_q == prra_pkg::IDX_RATE_HI;
	assign wr_ratelo = dwrite_q && didx_q == prra_pkg::IDX_RATE_LO;
	assign wr_durhi = dwrite_q && didx_q == prra_pkg::IDX_DUR_HI;
	assign wr_durlo = dwrite_q && didx_q == prra_pkg::IDX_DUR_LO;

	// ***************************************************************
	// control: continuous enable and self-clearing read/load commands
	// ***************************************************************
	logic cont_q, read_q, load_q;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cont_q <= 1'b0;
			read_q <= 1'b0;
			load_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				cont_q <= i_hwdata[prra_pkg::CTRL_CONT_BIT];
			end
			// load and read together: load wins, read is dropped
			load_q <= wr_ctrl && i_hwdata[prra_pkg::CTRL_LOAD_BIT];
			read_q <= wr_ctrl && i_hwdata[prra_pkg::CTRL_READ_BIT]
				&& !i_hwdata[prra_pkg::CTRL_LOAD_BIT];
		end
	end

	// ***************************************************************
	// time registers: software writes, read command overwrites
	// ***************************************************************
	logic [15:0] sec_hi_q, sec_lo_q, ns_hi_q, ns_lo_q;
	logic [2:0] phase_q;
	logic [31:0] live_sec, live_ns, live_frac;
	logic [2:0] live_phase;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sec_hi_q <= prra_pkg::REG_RESET;
			sec_lo_q <= prra_pkg::REG_RESET;
			ns_hi_q <= prra_pkg::REG_RESET;
			ns_lo_q <= prra_pkg::REG_RESET;
			phase_q <= 3'h0;
		end else if (read_q) begin
			sec_hi_q <= live_sec[31:16];
			sec_lo_q <= live_sec[15:0];
			ns_hi_q <= live_ns[31:16];
			ns_lo_q <= live_ns[15:0];
			phase_q <= live_phase;
		end else begin
			if (wr_sechi) sec_hi_q <= i_hwdata[15:0];
			if (wr_seclo) sec_lo_q <= i_hwdata[15:0];
			if (wr_nshi) ns_hi_q <= i_hwdata[15:0];
			if (wr_nslo) ns_lo_q <= i_hwdata[15:0];
			if (wr_phase) phase_q <= i_hwdata[2:0];
		end
	end

	// ***************************************************************
	// shared rate word, sign and duration
	// ***************************************************************
	logic sign_q;
	logic [29:0] rate_q;
	logic [15:0] dur_hi_q, dur_lo_q;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sign_q <= 1'b0;
			rate_q <= 30'h00000000;
			dur_hi_q <= prra_pkg::REG_RESET;
			dur_lo_q <= prra_pkg::REG_RESET;
		end else begin
			if (wr_ratehi) begin
				sign_q <= i_hwdata[prra_pkg::RATE_SIGN_BIT];
				rate_q[29:16] <= i_hwdata[prra_pkg::RATE_HI_W-1:0];
			end
			if (wr_ratelo) rate_q[15:0] <= i_hwdata[15:0];
			if (wr_durhi) dur_hi_q <= i_hwdata[15:0];
			if (wr_durlo) dur_lo_q <= i_hwdata[15:0];
		end
	end

	// ***************************************************************
	// temporary adjustment: counts timing periods, then stops itself
	// ***************************************************************
	prra_pkg::prra_tmp_state_t tmp_q;
	logic [31:0] count_q;
	logic adj_en;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			tmp_q <= prra_pkg::TMP_IDLE;
			count_q <= 32'h00000000;
		end else if (wr_ratehi) begin
			// a zero duration never starts, so the bit reads back clear
			if (i_hwdata[prra_pkg::RATE_TEMP_BIT] && {dur_hi_q, dur_lo_q} != 32'h00000000) begin
				tmp_q <= prra_pkg::TMP_RUN;
				count_q <= {dur_hi_q, dur_lo_q};
			end else begin
				tmp_q <= prra_pkg::TMP_IDLE;
				count_q <= 32'h00000000;
			end
		end else begin
			case (tmp_q)
				prra_pkg::TMP_RUN: begin
					if (i_tick && count_q == 32'h00000001) begin
						tmp_q <= prra_pkg::TMP_IDLE;
						count_q <= 32'h00000000;
					end else if (i_tick) begin
						count_q <= count_q - 32'h00000001;
					end
				end
				prra_pkg::TMP_IDLE: begin
					count_q <= 32'h00000000;
				end
				default: begin
					tmp_q <= prra_pkg::TMP_IDLE;
					count_q <= 32'h00000000;
				end
			endcase
		end
	end

	// one rate word, either mode enables it
	assign adj_en = cont_q || (tmp_q == prra_pkg::TMP_RUN);

	prra_time_core u_core (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_tick(i_tick),
		.i_load(load_q),
		.i_load_sec({sec_hi_q, sec_lo_q}),
		.i_load_ns({ns_hi_q, ns_lo_q}),
		.i_load_phase(phase_q),
		.i_adj_en(adj_en),
		.i_add(sign_q),
		.i_rate(rate_q),
		.o_sec(live_sec),
		.o_ns(live_ns),
		.o_phase(live_phase),
		.o_frac(live_frac)
	);

	// ***************************************************************
	// read data, registered in the address phase
	// ***************************************************************
	always_comb begin
		case (f_index(i_haddr))
			prra_pkg::IDX_CTRL: rd_mux = {13'h0000, cont_q, 2'h0};
			prra_pkg::IDX_PHASE: rd_mux = {13'h0000, phase_q};
			prra_pkg::IDX_NS_HI: rd_mux = ns_hi_q;
			prra_pkg::IDX_NS_LO: rd_mux = ns_lo_q;
			prra_pkg::IDX_SEC_HI: rd_mux = sec_hi_q;
			prra_pkg::IDX_SEC_LO: rd_mux = sec_lo_q;
			prra_pkg::IDX_RATE_HI: rd_mux = {sign_q, tmp_q == prra_pkg::TMP_RUN, rate_q[29:16]};
			prra_pkg::IDX_RATE_LO: rd_mux = rate_q[15:0];
			prra_pkg::IDX_DUR_HI: rd_mux = dur_hi_q;
			prra_pkg::IDX_DUR_LO: rd_mux = dur_lo_q;
			default: rd_mux = 16'h0000;
		endcase
	end

	// unmapped addresses read zero, writes to them are dropped
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			hrdata_q <= 32'h00000000;
		end else if (addr_ok && !i_hwrite) begin
			hrdata_q <= {16'h0000, rd_mux};
		end
	end

	assign o_hrdata = hrdata_q;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_live_sec = live_sec;
	assign o_live_ns = live_ns;
	assign o_adj_active = adj_en;

	// ***************************************************************
	// assertions
	// ***************************************************************
	sequence s_tick_adj_add;
		i_tick && !load_q && adj_en && sign_q;
	endsequence
	sequence s_tick_adj_sub;
		i_tick && !load_q && adj_en && !sign_q;
	endsequence
	sequence s_tick_idle;
		i_tick && !load_q && !adj_en;
	endsequence

	property p_sec_write;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_sechi && !read_q |=> sec_hi_q == $past(i_hwdata[15:0]);
	endproperty
	a_sec_write: assert property (p_sec_write) else $error("seconds upper write lost");

	property p_rate_lo;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_ratelo |=> rate_q[15:0] == $past(i_hwdata[15:0]);
	endproperty
	a_rate_lo: assert property (p_rate_lo) else $error("rate lower write lost");

	property p_add;
		@(posedge i_ref_clk) disable iff (i_rst)
		s_tick_adj_add |=> live_frac == $past(live_frac) + {2'h0, $past(rate_q)};
	endproperty
	a_add: assert property (p_add) else $error("rate not added");

	property p_sub;
		@(posedge i_ref_clk) disable iff (i_rst)
		s_tick_adj_sub |=> live_frac == $past(live_frac) - {2'h0, $past(rate_q)};
	endproperty
	a_sub: assert property (p_sub) else $error("rate not subtracted");

	property p_idle;
		@(posedge i_ref_clk) disable iff (i_rst)
		s_tick_idle |=> live_frac == $past(live_frac);
	endproperty
	a_idle: assert property (p_idle) else $error("fraction moved with no adjust");

	property p_temp_stop;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_ratehi && !i_hwdata[prra_pkg::RATE_TEMP_BIT] |=> tmp_q == prra_pkg::TMP_IDLE;
	endproperty
	a_temp_stop: assert property (p_temp_stop) else $error("temp adjust not stopped");

	property p_count;
		@(posedge i_ref_clk) disable iff (i_rst)
		tmp_q == prra_pkg::TMP_RUN && i_tick && !wr_ratehi && count_q > 32'h00000001
		|=> count_q == $past(count_q) - 32'h00000001 && tmp_q == prra_pkg::TMP_RUN;
	endproperty
	a_count: assert property (p_count) else $error("duration not counted");

	property p_end;
		@(posedge i_ref_clk) disable iff (i_rst)
		tmp_q == prra_pkg::TMP_RUN && i_tick && !wr_ratehi && count_q == 32'h00000001
		|=> tmp_q == prra_pkg::TMP_IDLE;
	endproperty
	a_end: assert property (p_end) else $error("temp adjust overran");

	property p_start;
		@(posedge i_ref_clk) disable iff (i_rst)
		wr_ratehi && i_hwdata[prra_pkg::RATE_TEMP_BIT] && {dur_hi_q, dur_lo_q} != 32'h00000000
		|=> tmp_q == prra_pkg::TMP_RUN && count_q == $past({dur_hi_q, dur_lo_q});
	endproperty
	a_start: assert property (p_start) else $error("temp adjust not started");

	property p_read;
		@(posedge i_ref_clk) disable iff (i_rst)
		read_q |=> {sec_hi_q, sec_lo_q} == $past(live_sec) && {ns_hi_q, ns_lo_q} == $past(live_ns);
	endproperty
	a_read: assert property (p_read) else $error("clock read not captured");

	property p_load;
		@(posedge i_ref_clk) disable iff (i_rst)
		load_q |=> live_sec == $past({sec_hi_q, sec_lo_q}) && live_ns == $past({ns_hi_q, ns_lo_q});
	endproperty
	a_load: assert property (p_load) else $error("clock load not applied");
endmodule
`default_nettype wire

//--- src/prra_time_core.sv
/*
 * Live clock: seconds, nanoseconds, 8 ns phase and a 32-bit sub-ns fraction.
 * Assumes i_tick pulses once per 40 ns timing period on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module prra_time_core (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// timing strobe and load
	input wire logic i_tick,
	input wire logic i_load,
	input wire logic [31:0] i_load_sec,
	input wire logic [31:0] i_load_ns,
	input wire logic [2:0] i_load_phase,
	// rate adjust
	input wire logic i_adj_en,
	input wire logic i_add,
	input wire logic [29:0] i_rate,
	// live time
	output logic [31:0] o_sec,
	output logic [31:0] o_ns,
	output logic [2:0] o_phase,
	output logic [31:0] o_frac
);
	logic [31:0] sec_q, sec_d, ns_q, ns_d, frac_q, frac_d, ns_sum;
	logic [32:0] frac_sum, frac_dif;
	logic [31:0] ns_step;
	logic [2:0] phase_q;

	// ***************************************************************
	// next time: nominal 40 ns plus carry or minus borrow of the fraction
	// ***************************************************************
	always_comb begin
		frac_sum = {1'b0, frac_q} + {3'h0, i_rate};
		frac_dif = {1'b0, frac_q} - {3'h0, i_rate};
		frac_d = frac_q;
		ns_step = prra_pkg::TICK_PERIOD_NS;
		if (i_adj_en && i_add) begin
			frac_d = frac_sum[31:0];
			ns_step = prra_pkg::TICK_PERIOD_NS + {31'h0, frac_sum[32]};
		end else if (i_adj_en) begin
			frac_d = frac_dif[31:0];
			ns_step = prra_pkg::TICK_PERIOD_NS - {31'h0, frac_dif[32]};
		end
		ns_sum = ns_q + ns_step;
		ns_d = ns_sum;
		sec_d = sec_q;
		if (ns_sum >= prra_pkg::NS_PER_SEC) begin
			ns_d = ns_sum - prra_pkg::NS_PER_SEC;
			sec_d = sec_q + 32'h00000001;
		end
	end

	// load beats the tick so software always sees its own value land
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sec_q <= 32'h00000000;
			ns_q <= 32'h00000000;
			frac_q <= 32'h00000000;
			phase_q <= 3'h0;
		end else if (i_load) begin
			sec_q <= i_load_sec;
			ns_q <= i_load_ns;
			phase_q <= i_load_phase;
			frac_q <= 32'h00000000;
		end else if (i_tick) begin
			sec_q <= sec_d;
			ns_q <= ns_d;
			frac_q <= frac_d;
		end
	end

	assign o_sec = sec_q;
	assign o_ns = ns_q;
	assign o_phase = phase_q;
	assign o_frac = frac_q;
endmodule
`default_nettype wire
